/* File: shared/sm2_pkg.sv */
// Constants, types and register map of the second-motor parameter bank.
// Assumes one 32-bit AHB-Lite slave port; each register is one word.
package sm2_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_ACC1_HI = 14'h2103;
  localparam logic [13:0] IDX_ACC1_LO = 14'h2104;
  localparam logic [13:0] IDX_DEC1_HI = 14'h2105;
  localparam logic [13:0] IDX_DEC1_LO = 14'h2106;
  localparam logic [13:0] IDX_BASE = 14'h2203;
  localparam logic [13:0] IDX_MAXF = 14'h2204;
  localparam logic [13:0] IDX_STEP_HI = 14'h2216;
  localparam logic [13:0] IDX_STEP_LO = 14'h2217;
  localparam logic [13:0] IDX_BOOST = 14'h223B;
  localparam logic [13:0] IDX_MB_VOLT = 14'h223C;
  localparam logic [13:0] IDX_MB_BREAK = 14'h223D;
  localparam logic [13:0] IDX_METHOD = 14'h223E;
  localparam logic [13:0] IDX_VGAIN = 14'h2240;
  localparam logic [13:0] IDX_SGAIN = 14'h2241;
  localparam logic [13:0] IDX_CEIL_HI = 14'h224F;
  localparam logic [13:0] IDX_CEIL_LO = 14'h2250;
  localparam logic [13:0] IDX_FLOOR_HI = 14'h2251;
  localparam logic [13:0] IDX_FLOOR_LO = 14'h2252;
  localparam logic [13:0] IDX_ACC2_HI = 14'h226F;
  localparam logic [13:0] IDX_ACC2_LO = 14'h2270;
  localparam logic [13:0] IDX_DEC2_HI = 14'h2271;
  localparam logic [13:0] IDX_DEC2_LO = 14'h2272;
  localparam logic [13:0] IDX_STATUS = 14'h2000;

  // Status fields
  localparam int STAT_REJECT = 0;
  localparam int STAT_PEND = 1;

  // ----------------------------------------------------------------
  // Ranges in raw units (0.01 s, 1 Hz, 0.01 Hz, 0.1 %)
  // ----------------------------------------------------------------
  localparam logic [31:0] TIME_MIN = 32'h0000_0001;
  localparam logic [31:0] TIME_MAX = 32'h0005_7E40;
  localparam logic [15:0] FREQ_MIN = 16'h001E;
  localparam logic [15:0] FREQ_MAX = 16'h0190;
  localparam logic [31:0] HZ_TO_CENTI = 32'h0000_0064;
  localparam logic [15:0] MB_VOLT_MAX = 16'h00C8;
  localparam logic [15:0] MB_BREAK_MAX = 16'h01F4;
  localparam logic [15:0] GAIN_MAX = 16'h00FF;
  localparam logic [15:0] BOOST_MAX = 16'h0001;
  localparam logic [15:0] METHOD_MAX = 16'h0005;

  // Reset values
  localparam logic [31:0] RST_TIME = 32'h0000_0BB8;
  localparam logic [15:0] RST_FREQ = 16'h003C;

  typedef enum logic {
    SM2_BOOST_MANUAL = 1'b0,
    SM2_BOOST_AUTO = 1'b1
  } sm2_boost_e;

  typedef enum logic [2:0] {
    SM2_CONSTANT_TORQUE_CURVE = 3'h0,
    SM2_REDUCED_TORQUE_CURVE = 3'h1,
    SM2_FREE_CURVE = 3'h2,
    SM2_SENSORLESS_VECTOR_MODE = 3'h3,
    SM2_ZERO_HZ_SENSORLESS_MODE = 3'h4,
    SM2_ENCODER_VECTOR_MODE = 3'h5
  } sm2_method_e;

  typedef struct packed {
    logic [31:0] accel_one;
    logic [31:0] decel_one;
    logic [15:0] base_freq;
    logic [15:0] max_freq;
    logic [31:0] step_speed_zero;
    sm2_boost_e boost_choice;
    logic [15:0] manual_boost_volt;
    logic [15:0] manual_boost_break;
    sm2_method_e control_method;
    logic [7:0] auto_boost_volt_gain;
    logic [7:0] auto_boost_slip_gain;
    logic [31:0] freq_ceiling;
    logic [31:0] freq_floor;
    logic [31:0] accel_two;
    logic [31:0] decel_two;
  } sm2_cfg_s;

endpackage

/* File: rtl/sm2_param_bank.sv */
// Second-motor parameter bank: range-checked holding registers.
// Assumes an AHB-Lite master on hclk and a same-clock start frequency.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Accel time one: word pair, 1..360000
// - Decel time one: word pair, 1..360000
// - Base 30..max; max 30..400 Hz
// - Step speed zero: pair, 0..max frequency
// - Boost choice: 0 manual, 1 automatic
// - Manual boost volt 0..200 tenths percent
// - Manual boost break 0..500 tenths percent
// - Control method codes 0..5 only
// - Ceiling: 0, or floor..max frequency
// - Floor: 0, or start..ceiling (start..max frequency while ceiling is 0)
// - Accel time two: pair, 1..360000
// - Decel time two: pair, 1..360000
module sm2_param_bank (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Motor side
  input wire logic [15:0] start_freq,
  output sm2_pkg::sm2_cfg_s cfg
);
  import sm2_pkg::*;

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  logic dph_valid;
  logic dph_write;
  logic [13:0] dph_idx;
  logic wr_en;
  logic [15:0] wd;
  logic [15:0] stage;
  logic [13:0] stage_idx;
  logic pend;
  logic rej_flag;
  logic [15:0] next_stage;
  logic [13:0] next_stage_idx;
  logic next_pend;
  logic reject;
  logic clr_rej;
  sm2_cfg_s next_cfg;
  logic [31:0] val32;
  logic pair_ok;
  logic is_hi;
  logic t_ok;
  logic [31:0] max_centi;
  logic [31:0] wd_centi;
  logic [31:0] floor_top;
  logic [15:0] rd_word;

  // Zero wait states; hsize is not checked, only words are expected
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_idx <= 14'h0000;
    end else if (hready) begin
      dph_valid <= hsel && htrans[1] && (haddr[31:16] == 16'h0000)
                   && (haddr[1:0] == 2'b00);
      dph_write <= hwrite;
      dph_idx <= haddr[15:2];
    end
  end

  assign wr_en = dph_valid && dph_write;
  assign wd = hwdata[15:0];
  assign val32 = {stage, wd};
  assign pair_ok = pend && (stage_idx == 14'(dph_idx - 14'h0001));
  assign t_ok = (val32 >= TIME_MIN) && (val32 <= TIME_MAX);
  assign max_centi = 32'({16'h0000, cfg.max_freq} * HZ_TO_CENTI);
  assign wd_centi = 32'({16'h0000, wd} * HZ_TO_CENTI);
  // With the ceiling off (zero) the floor is bounded by max frequency
  assign floor_top = (cfg.freq_ceiling == 32'h0000_0000) ? max_centi
                     : cfg.freq_ceiling;
  assign is_hi = (dph_idx == IDX_ACC1_HI) || (dph_idx == IDX_DEC1_HI)
              || (dph_idx == IDX_STEP_HI) || (dph_idx == IDX_CEIL_HI)
              || (dph_idx == IDX_FLOOR_HI) || (dph_idx == IDX_ACC2_HI)
              || (dph_idx == IDX_DEC2_HI);

  // ----------------------------------------------------------------
  // Write decode and range checks
  // ----------------------------------------------------------------
  // A high word is only staged; the pair is checked and committed as a
  // whole on the low-word write, so the drive never sees half a value.
  always_comb begin
    next_cfg = cfg;
    next_stage = stage;
    next_stage_idx = stage_idx;
    next_pend = pend;
    reject = 1'b0;
    clr_rej = 1'b0;
    if (wr_en) begin
      if (dph_idx != IDX_STATUS) begin
        next_pend = 1'b0;
      end
      if (is_hi) begin
        next_stage = wd;
        next_stage_idx = dph_idx;
        next_pend = 1'b1;
      end else if (dph_idx == IDX_STATUS) begin
        clr_rej = hwdata[STAT_REJECT];
      end else if (dph_idx == IDX_ACC1_LO) begin
        if (pair_ok && t_ok) next_cfg.accel_one = val32;
        else reject = 1'b1;
      end else if (dph_idx == IDX_DEC1_LO) begin
        if (pair_ok && t_ok) next_cfg.decel_one = val32;
        else reject = 1'b1;
      end else if (dph_idx == IDX_BASE) begin
        if (wd >= FREQ_MIN && wd <= cfg.max_freq) begin
          next_cfg.base_freq = wd;
        end else begin
          reject = 1'b1;
        end
      end else if (dph_idx == IDX_MAXF) begin
        // Lowering max below a dependent value would break its range
        if (wd >= FREQ_MIN && wd <= FREQ_MAX && wd >= cfg.base_freq
            && wd_centi >= cfg.step_speed_zero
            && wd_centi >= cfg.freq_ceiling
            && wd_centi >= cfg.freq_floor) begin
          next_cfg.max_freq = wd;
        end else begin
          reject = 1'b1;
        end
      end else if (dph_idx == IDX_STEP_LO) begin
        if (pair_ok && val32 <= max_centi) begin
          next_cfg.step_speed_zero = val32;
        end else begin
          reject = 1'b1;
        end
      end else if (dph_idx == IDX_BOOST) begin
        if (wd <= BOOST_MAX) begin
          next_cfg.boost_choice = sm2_boost_e'(wd[0]);
        end else begin
          reject = 1'b1;
        end
      end else if (dph_idx == IDX_MB_VOLT) begin
        if (wd <= MB_VOLT_MAX) next_cfg.manual_boost_volt = wd;
        else reject = 1'b1;
      end else if (dph_idx == IDX_MB_BREAK) begin
        if (wd <= MB_BREAK_MAX) next_cfg.manual_boost_break = wd;
        else reject = 1'b1;
      end else if (dph_idx == IDX_METHOD) begin
        if (wd <= METHOD_MAX) begin
          next_cfg.control_method = sm2_method_e'(wd[2:0]);
        end else begin
          reject = 1'b1;
        end
      end else if (dph_idx == IDX_VGAIN) begin
        if (wd <= GAIN_MAX) next_cfg.auto_boost_volt_gain = wd[7:0];
        else reject = 1'b1;
      end else if (dph_idx == IDX_SGAIN) begin
        if (wd <= GAIN_MAX) next_cfg.auto_boost_slip_gain = wd[7:0];
        else reject = 1'b1;
      end else if (dph_idx == IDX_CEIL_LO) begin
        if (pair_ok && (val32 == 32'h0000_0000 || (val32 >= cfg.freq_floor
            && val32 <= max_centi))) begin
          next_cfg.freq_ceiling = val32;
        end else begin
          reject = 1'b1;
        end
      end else if (dph_idx == IDX_FLOOR_LO) begin
        if (pair_ok && (val32 == 32'h0000_0000 || (val32 >= 32'(start_freq)
            && val32 <= floor_top))) begin
          next_cfg.freq_floor = val32;
        end else begin
          reject = 1'b1;
        end
      end else if (dph_idx == IDX_ACC2_LO) begin
        if (pair_ok && t_ok) next_cfg.accel_two = val32;
        else reject = 1'b1;
      end else if (dph_idx == IDX_DEC2_LO) begin
        if (pair_ok && t_ok) next_cfg.decel_two = val32;
        else reject = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stored state
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg.accel_one <= RST_TIME;
      cfg.decel_one <= RST_TIME;
      cfg.base_freq <= RST_FREQ;
      cfg.max_freq <= RST_FREQ;
      cfg.step_speed_zero <= 32'h0000_0000;
      cfg.boost_choice <= SM2_BOOST_MANUAL;
      cfg.manual_boost_volt <= 16'h0000;
      cfg.manual_boost_break <= 16'h0000;
      cfg.control_method <= SM2_CONSTANT_TORQUE_CURVE;
      cfg.auto_boost_volt_gain <= 8'h00;
      cfg.auto_boost_slip_gain <= 8'h00;
      cfg.freq_ceiling <= 32'h0000_0000;
      cfg.freq_floor <= 32'h0000_0000;
      cfg.accel_two <= RST_TIME;
      cfg.decel_two <= RST_TIME;
    end else begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage <= 16'h0000;
      stage_idx <= 14'h0000;
      pend <= 1'b0;
    end else begin
      stage <= next_stage;
      stage_idx <= next_stage_idx;
      pend <= next_pend;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rej_flag <= 1'b0;
    end else begin
      rej_flag <= (rej_flag && !clr_rej) || reject;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // High words read the committed value, not the staged one
  always_comb begin
    if (dph_idx == IDX_ACC1_HI) rd_word = cfg.accel_one[31:16];
    else if (dph_idx == IDX_ACC1_LO) rd_word = cfg.accel_one[15:0];
    else if (dph_idx == IDX_DEC1_HI) rd_word = cfg.decel_one[31:16];
    else if (dph_idx == IDX_DEC1_LO) rd_word = cfg.decel_one[15:0];
    else if (dph_idx == IDX_BASE) rd_word = cfg.base_freq;
    else if (dph_idx == IDX_MAXF) rd_word = cfg.max_freq;
    else if (dph_idx == IDX_STEP_HI) rd_word = cfg.step_speed_zero[31:16];
    else if (dph_idx == IDX_STEP_LO) rd_word = cfg.step_speed_zero[15:0];
    else if (dph_idx == IDX_BOOST) rd_word = {15'h0000, cfg.boost_choice};
    else if (dph_idx == IDX_MB_VOLT) rd_word = cfg.manual_boost_volt;
    else if (dph_idx == IDX_MB_BREAK) rd_word = cfg.manual_boost_break;
    else if (dph_idx == IDX_METHOD) rd_word = {13'h0000, cfg.control_method};
    else if (dph_idx == IDX_VGAIN) rd_word = {8'h00, cfg.auto_boost_volt_gain};
    else if (dph_idx == IDX_SGAIN) rd_word = {8'h00, cfg.auto_boost_slip_gain};
    else if (dph_idx == IDX_CEIL_HI) rd_word = cfg.freq_ceiling[31:16];
    else if (dph_idx == IDX_CEIL_LO) rd_word = cfg.freq_ceiling[15:0];
    else if (dph_idx == IDX_FLOOR_HI) rd_word = cfg.freq_floor[31:16];
    else if (dph_idx == IDX_FLOOR_LO) rd_word = cfg.freq_floor[15:0];
    else if (dph_idx == IDX_ACC2_HI) rd_word = cfg.accel_two[31:16];
    else if (dph_idx == IDX_ACC2_LO) rd_word = cfg.accel_two[15:0];
    else if (dph_idx == IDX_DEC2_HI) rd_word = cfg.decel_two[31:16];
    else if (dph_idx == IDX_DEC2_LO) rd_word = cfg.decel_two[15:0];
    else if (dph_idx == IDX_STATUS) rd_word = {14'h0000, pend, rej_flag};
    else rd_word = 16'h0000;
  end

  assign hrdata = (dph_valid && !dph_write) ? {16'h0000, rd_word}
                  : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_wr(logic [13:0] idx);
    wr_en && (dph_idx == idx);
  endsequence

  sequence s_pair_commit(logic [13:0] idx);
    wr_en && (dph_idx == idx) && pair_ok && t_ok;
  endsequence

  // Single-word write above its upper limit
  sequence s_bad_word(logic [13:0] idx, logic [15:0] top);
    wr_en && (dph_idx == idx) && (wd > top);
  endsequence

  chk_accel_one_pair:
  assert property (s_pair_commit(IDX_ACC1_LO)
                   |=> cfg.accel_one == $past(val32))
    else $error("accel one pair not committed");

  chk_decel_one_pair:
  assert property (s_pair_commit(IDX_DEC1_LO)
                   |=> cfg.decel_one == $past(val32))
    else $error("decel one pair not committed");

  chk_high_word_staged:
  assert property (wr_en && is_hi |=> pend && stage == $past(wd))
    else $error("high word not staged");

  chk_decel_two_range:
  assert property (cfg.decel_two >= TIME_MIN && cfg.decel_two <= TIME_MAX)
    else $error("decel two out of range");

  chk_decel_one_range:
  assert property (cfg.decel_one >= TIME_MIN && cfg.decel_one <= TIME_MAX)
    else $error("decel one out of range");

  chk_base_under_max:
  assert property (cfg.base_freq >= FREQ_MIN && cfg.base_freq <= cfg.max_freq
                   && cfg.max_freq <= FREQ_MAX)
    else $error("base or max frequency out of range");

  chk_step_under_max:
  assert property (cfg.step_speed_zero <= max_centi)
    else $error("step speed above max frequency");

  chk_boost_bad_code:
  assert property (s_bad_word(IDX_BOOST, BOOST_MAX)
                   |=> $stable(cfg.boost_choice) && rej_flag)
    else $error("bad boost code altered setting");

  chk_volt_bad_value:
  assert property (s_bad_word(IDX_MB_VOLT, MB_VOLT_MAX)
                   |=> $stable(cfg.manual_boost_volt))
    else $error("bad boost voltage altered setting");

  chk_break_bad_value:
  assert property (s_bad_word(IDX_MB_BREAK, MB_BREAK_MAX)
                   |=> $stable(cfg.manual_boost_break))
    else $error("bad break point altered setting");

  chk_method_range:
  assert property (cfg.control_method <= 3'(METHOD_MAX))
    else $error("control method code out of range");

  chk_ceiling_span:
  assert property (cfg.freq_ceiling == 32'h0000_0000
                   || (cfg.freq_ceiling >= cfg.freq_floor
                   && cfg.freq_ceiling <= max_centi))
    else $error("ceiling out of range");

  chk_floor_span:
  assert property (cfg.freq_floor <= max_centi
                   && (cfg.freq_ceiling == 32'h0000_0000
                   || cfg.freq_floor <= cfg.freq_ceiling))
    else $error("floor out of range");

  chk_accel_two_pair:
  assert property (s_wr(IDX_ACC2_HI) ##[1:8] s_pair_commit(IDX_ACC2_LO)
                   |=> cfg.accel_two == {$past(stage), $past(wd)})
    else $error("accel two pair not committed");

  chk_reject_keeps:
  assert property (reject |=> $stable(cfg) && rej_flag)
    else $error("rejected write changed a value");

  chk_reject_sticks:
  assert property (reject ##1 !clr_rej |=> rej_flag)
    else $error("reject flag lost without a clear");

  chk_orphan_low_word:
  assert property (wr_en && dph_idx == IDX_ACC1_LO && !pend
                   |=> $stable(cfg.accel_one) && rej_flag)
    else $error("unpaired low word was accepted");

endmodule

`default_nettype wire

/* File: verification/sm2_bus_master.sv */
// Bus master model standing for the network master of the parameter bank.
// Assumes one slave whose hreadyout is looped back as hready.
`timescale 1ns/10ps
`default_nettype none

module sm2_bus_master (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus towards the bank
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Read results seen on the bus
  output logic rd_valid,
  output logic [31:0] rd_word
);
  logic dp_read;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // One single word transfer, address phase then data phase
  // ----------------------------------------------------------------
  task automatic xfer(input logic [13:0] idx, input logic wr,
                      input logic [15:0] data);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {16'h0000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, data};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    // Released data must not look like a still valid word
    hwdata <= ~{16'h0000, data};
  endtask

  // ----------------------------------------------------------------
  // Passive capture of read data at the end of each data phase
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_read <= 1'b0;
      rd_valid <= 1'b0;
      rd_word <= 32'h0000_0000;
    end else begin
      rd_valid <= dp_read & hready;
      rd_word <= hrdata;
      if (hready) begin
        dp_read <= hsel & htrans[1] & ~hwrite;
      end
    end
  end
endmodule

`default_nettype wire

/* File: verification/sm2_param_bank_test.sv */
// Self-checking bench of the second-motor parameter bank.
// Assumes the bus master model drives the bank's only slave port.
`timescale 1ns/10ps
`default_nettype none

module sm2_param_bank_test;
  import sm2_pkg::*;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, rd_valid;
  logic [31:0] haddr, hwdata, hrdata, rd_word, v, f;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] start_freq, w;
  logic [13:0] ux;
  wire logic hready;
  sm2_cfg_s cfg;
  logic [31:0] exp_q[$];
  int err_total, checked;
  logic [13:0] tpair[4] = '{IDX_ACC1_HI, IDX_DEC1_HI, IDX_ACC2_HI,
                            IDX_DEC2_HI};
  logic [13:0] sidx[6] = '{IDX_BOOST, IDX_MB_VOLT, IDX_MB_BREAK,
                           IDX_METHOD, IDX_VGAIN, IDX_SGAIN};
  logic [15:0] smax[6] = '{BOOST_MAX, MB_VOLT_MAX, MB_BREAK_MAX,
                           METHOD_MAX, GAIN_MAX, GAIN_MAX};

  assign hready = hreadyout;

  sm2_param_bank u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .start_freq(start_freq), .cfg(cfg));

  sm2_bus_master u_mst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .rd_valid(rd_valid), .rd_word(rd_word));

  always #25 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    u_mst.xfer(idx, 1'b1, d);
  endtask

  task automatic rd(input logic [13:0] idx, input logic [15:0] e);
    exp_q.push_back({16'h0000, e});
    u_mst.xfer(idx, 1'b0, 16'h0000);
  endtask

  // High word first, low word as the very next write
  task automatic wr32(input logic [13:0] hi, input logic [31:0] d);
    wr(hi, d[31:16]);
    wr(hi + 14'h1, d[15:0]);
  endtask

  task automatic rd32(input logic [13:0] hi, input logic [31:0] e);
    rd(hi, e[31:16]);
    rd(hi + 14'h1, e[15:0]);
  endtask

  // Oldest note is matched against each completed read
  always @(posedge hclk) begin
    if (rd_valid === 1'b1) begin
      check("hrdata", rd_word, exp_q.pop_front());
      check("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    start_freq = 16'h0000;
    void'($urandom(29));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    start_freq <= 16'h0064 + 16'($urandom_range(0, 900));
    foreach (tpair[i]) rd32(tpair[i], RST_TIME);
    rd(IDX_BASE, RST_FREQ);
    // Time pairs: both ends of the range, just outside, then random
    foreach (tpair[i]) begin
      v = 32'($urandom_range(1, 360000));
      wr32(tpair[i], TIME_MIN);
      rd32(tpair[i], TIME_MIN);
      wr32(tpair[i], TIME_MAX);
      wr32(tpair[i], TIME_MAX + 32'h1);
      wr32(tpair[i], 32'h0000_0000);
      rd32(tpair[i], TIME_MAX);
      wr32(tpair[i], v);
      rd32(tpair[i], v);
    end
    @(negedge hclk);
    check("decel_two", cfg.decel_two, v);
    wr(IDX_ACC1_LO, 16'h0005);
    rd(IDX_STATUS, 16'h0001);
    wr(IDX_STATUS, 16'h0001);
    wr(IDX_ACC1_HI, 16'h0000);
    rd(IDX_STATUS, 16'h0002);
    wr(IDX_ACC1_LO, 16'h0007);
    rd32(IDX_ACC1_HI, 32'h0000_0007);
    // Maximum and base frequency
    wr(IDX_MAXF, FREQ_MAX);
    wr(IDX_MAXF, FREQ_MAX + 16'h1);
    wr(IDX_MAXF, FREQ_MIN - 16'h1);
    rd(IDX_MAXF, FREQ_MAX);
    wr(IDX_BASE, FREQ_MIN - 16'h1);
    rd(IDX_BASE, RST_FREQ);
    wr(IDX_BASE, FREQ_MAX);
    rd(IDX_BASE, FREQ_MAX);
    wr(IDX_BASE, FREQ_MIN);
    wr(IDX_MAXF, 16'h0064);
    // Step speed bounded by the maximum of 100 Hz
    wr32(IDX_STEP_HI, 32'd10000);
    wr32(IDX_STEP_HI, 32'd10001);
    rd32(IDX_STEP_HI, 32'd10000);
    wr(IDX_MAXF, 16'h0063);
    rd(IDX_MAXF, 16'h0064);
    // Single-word settings at the limit, past it, then random
    foreach (sidx[i]) begin
      w = 16'($urandom_range(0, int'(smax[i])));
      wr(sidx[i], smax[i]);
      wr(sidx[i], smax[i] + 16'h1);
      rd(sidx[i], smax[i]);
      wr(sidx[i], w);
      rd(sidx[i], w);
    end
    for (int m = 0; m < 6; m++) begin
      wr(IDX_METHOD, 16'(m));
      wr(IDX_BOOST, 16'(m % 2));
      @(negedge hclk);
      check("method", 32'(cfg.control_method), 32'(m));
      check("boost", 32'(cfg.boost_choice), 32'(m % 2));
    end
    // Ceiling and floor against maximum, start and each other
    f = {16'h0000, start_freq};
    wr32(IDX_CEIL_HI, 32'd10001);
    rd32(IDX_CEIL_HI, 32'h0000_0000);
    wr32(IDX_CEIL_HI, 32'd10000);
    wr32(IDX_FLOOR_HI, f - 32'h1);
    rd32(IDX_FLOOR_HI, 32'h0000_0000);
    wr32(IDX_FLOOR_HI, f);
    rd32(IDX_FLOOR_HI, f);
    wr32(IDX_CEIL_HI, f - 32'h1);
    rd32(IDX_CEIL_HI, 32'd10000);
    wr32(IDX_FLOOR_HI, 32'd10001);
    rd32(IDX_FLOOR_HI, f);
    wr32(IDX_CEIL_HI, f);
    rd32(IDX_CEIL_HI, f);
    // Hole in the map: write ignored, read zero
    ux = 14'h2107 + 14'($urandom_range(0, 251));
    wr(ux, 16'($urandom()));
    rd(ux, 16'h0000);
    repeat (4) @(posedge hclk);
    check("pending", 32'(exp_q.size()), 32'h0000_0000);
    summarize();
  end
endmodule

`default_nettype wire
